// ---- hw/ccr_regs.sv ----
// Channel configuration and calibration register bank on AHB-Lite
// What this block does
// - Offset is 24 bits; high offset word holds bits 23:8 entirely.
// - Low offset bits sit in 15:8 of low word; 7:0 read zero.
// - High offset word resets to zero.
// - Gain is 24 bits; high gain word holds bits 23:8 entirely.
// - Low gain bits sit in 15:8 of low word; 7:0 read zero.
// - High gain word resets to 8000h; low gain word resets to zero.
// - Config bits 15:6 hold signed ten-bit phase delay, reset zero.
// - Config bit 2 set bypasses DC filter for the channel only.
// - Config bits 1:0 select pins, shorted, positive or negative test.
// - Config bits 5:3 read zero; config resets to zero.
// - Channel 1 takes word addresses Eh through 12h.
// - Global four-bit DC setting: zero disables, else coefficient halves.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [23:0] ch0_offset,
  output logic      [23:0] ch0_gain,
  output logic      [23:0] ch1_offset,
  output logic      [23:0] ch1_gain,
  output logic signed [9:0] ch1_phase_delay,
  output logic             ch1_dc_filter_active,
  output var ccr_input_type ch1_input_select,
  output logic      [4:0]  ch1_dc_shift
);
  logic [15:0] ch0_offset_high;
  logic [7:0]  ch0_offset_low_bits;
  logic [15:0] ch0_gain_high_bits;
  logic [7:0]  ch0_gain_low_bits;
  logic [9:0]  phase;
  logic        ch1_dc_filter_bypass;
  logic [1:0]  mux;
  logic [15:0] ch1_offset_high_bits;
  logic [7:0]  ch1_offset_low_bits;
  logic [15:0] ch1_gain_high_bits;
  logic [7:0]  ch1_gain_low_bits;
  logic [3:0]  global_dc_filter_coeff;
  logic        wr_pend;
  logic [4:0]  wr_idx;
  logic [15:0] next_rdata;
  logic [4:0]  a_idx;
  logic        take;
  logic        rd_clash;
  logic        rd_stall;
  logic [4:0]  rd_idx;
  logic        rd_mapped;
  logic [4:0]  sel_idx;
  logic        sel_mapped;

  assign a_idx      = haddr[6:2];
  assign take       = hsel && hready && htrans[1];
  assign rd_clash   = take && !hwrite && wr_pend;
  assign sel_idx    = rd_stall ? rd_idx : a_idx;
  assign sel_mapped = rd_stall ? rd_mapped : (haddr[31:7] == 25'h0000000);

  // A read meeting a write in its data phase would see the old word:
  // one wait state lets the write land before the read data is loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_stall  <= 1'b0;
      rd_idx    <= 5'h00;
      rd_mapped <= 1'b0;
    end else begin
      rd_stall  <= rd_clash;
      rd_idx    <= a_idx;
      rd_mapped <= (haddr[31:7] == 25'h0000000);
    end
  end

  // Write intent captured in address phase, applied in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 5'h00;
    end else begin
      wr_pend <= take && hwrite && (haddr[31:7] == 25'h0000000);
      wr_idx  <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch0_offset_high        <= `CCR_RST_OFFSET_HIGH;
      ch0_offset_low_bits    <= `CCR_RST_LOW_BYTE;
      ch0_gain_high_bits     <= `CCR_RST_GAIN_HIGH;
      ch0_gain_low_bits      <= `CCR_RST_LOW_BYTE;
      phase                  <= `CCR_RST_PHASE;
      ch1_dc_filter_bypass   <= `CCR_RST_BYPASS;
      mux                    <= `CCR_RST_MUX;
      ch1_offset_high_bits   <= `CCR_RST_OFFSET_HIGH;
      ch1_offset_low_bits    <= `CCR_RST_LOW_BYTE;
      ch1_gain_high_bits     <= `CCR_RST_GAIN_HIGH;
      ch1_gain_low_bits      <= `CCR_RST_LOW_BYTE;
      global_dc_filter_coeff <= `CCR_RST_DC_COEFF;
    end else if (wr_pend) begin
      // Reserved bits are never stored
      case (wr_idx)
        `CCR_IDX_CH0_OFFSET_HIGH: ch0_offset_high <= hwdata[15:0];
        `CCR_IDX_CH0_OFFSET_LOW:  ch0_offset_low_bits <= hwdata[15:8];
        `CCR_IDX_CH0_GAIN_HIGH:   ch0_gain_high_bits <= hwdata[15:0];
        `CCR_IDX_CH0_GAIN_LOW:    ch0_gain_low_bits <= hwdata[15:8];
        `CCR_IDX_CH1_CONFIG: begin
          phase                <= hwdata[`CCR_CFG_PHASE_MSB:`CCR_CFG_PHASE_LSB];
          ch1_dc_filter_bypass <= hwdata[`CCR_CFG_BYPASS_BIT];
          mux                  <= hwdata[`CCR_CFG_MUX_MSB:`CCR_CFG_MUX_LSB];
        end
        `CCR_IDX_CH1_OFFSET_HIGH: ch1_offset_high_bits <= hwdata[15:0];
        `CCR_IDX_CH1_OFFSET_LOW:  ch1_offset_low_bits <= hwdata[15:8];
        `CCR_IDX_CH1_GAIN_HIGH:   ch1_gain_high_bits <= hwdata[15:0];
        `CCR_IDX_CH1_GAIN_LOW:    ch1_gain_low_bits <= hwdata[15:8];
        `CCR_IDX_GLOBAL_DC:       global_dc_filter_coeff <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (sel_idx)
      `CCR_IDX_CH0_OFFSET_HIGH: next_rdata = ch0_offset_high;
      `CCR_IDX_CH0_OFFSET_LOW:  next_rdata = {ch0_offset_low_bits, 8'h00};
      `CCR_IDX_CH0_GAIN_HIGH:   next_rdata = ch0_gain_high_bits;
      `CCR_IDX_CH0_GAIN_LOW:    next_rdata = {ch0_gain_low_bits, 8'h00};
      `CCR_IDX_CH1_CONFIG:      next_rdata = {phase, 3'b000, ch1_dc_filter_bypass, mux};
      `CCR_IDX_CH1_OFFSET_HIGH: next_rdata = ch1_offset_high_bits;
      `CCR_IDX_CH1_OFFSET_LOW:  next_rdata = {ch1_offset_low_bits, 8'h00};
      `CCR_IDX_CH1_GAIN_HIGH:   next_rdata = ch1_gain_high_bits;
      `CCR_IDX_CH1_GAIN_LOW:    next_rdata = {ch1_gain_low_bits, 8'h00};
      `CCR_IDX_GLOBAL_DC:       next_rdata = {12'h000, global_dc_filter_coeff};
      default:                  next_rdata = 16'h0000;
    endcase
    if (!sel_mapped) begin
      next_rdata = 16'h0000;
    end
  end

  // Read data registered at the address phase; OKAY, waits only on a clash
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !rd_clash;
      hresp     <= 1'b0;
      if (rd_stall || (take && !hwrite && !wr_pend)) begin
        hrdata <= {16'h0000, next_rdata};
      end
    end
  end

  // Calibration words and channel controls to the filter datapath
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch0_offset           <= 24'h000000;
      ch0_gain             <= 24'h800000;
      ch1_offset           <= 24'h000000;
      ch1_gain             <= 24'h800000;
      ch1_phase_delay      <= 10'sh000;
      ch1_dc_filter_active <= 1'b0;
      ch1_input_select     <= CCR_IN_PINS;
      ch1_dc_shift         <= 5'h00;
    end else begin
      ch0_offset           <= {ch0_offset_high, ch0_offset_low_bits};
      ch0_gain             <= {ch0_gain_high_bits, ch0_gain_low_bits};
      ch1_offset           <= {ch1_offset_high_bits, ch1_offset_low_bits};
      ch1_gain             <= {ch1_gain_high_bits, ch1_gain_low_bits};
      ch1_phase_delay      <= $signed(phase);
      // Active only if globally enabled and not bypassed locally
      ch1_dc_filter_active <= (global_dc_filter_coeff != 4'h0) && !ch1_dc_filter_bypass;
      ch1_input_select     <= ccr_input_type'(mux);
      // Coefficient 2^-(coeff+1): 1/4 at 0001b down to 1/65536 at 1111b
      ch1_dc_shift         <= (global_dc_filter_coeff == 4'h0) ? 5'h00
                              : 5'({1'b0, global_dc_filter_coeff} + 5'h01);
    end
  end

  property p_gain_reset_value;
    @(posedge hclk) $rose(hresetn) |-> (ch0_gain == 24'h800000) && (ch1_gain == 24'h800000);
  endproperty
  a_gain_reset_value: assert property (p_gain_reset_value) else $error("gain reset wrong");

  property p_offset_reset_value;
    @(posedge hclk) $rose(hresetn) |-> (ch0_offset == 24'h000000) && (ch1_offset == 24'h000000);
  endproperty
  a_offset_reset_value: assert property (p_offset_reset_value) else $error("offset reset wrong");

  property p_low_byte_zero;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && (haddr[31:7] == 25'h0000000) && (a_idx == `CCR_IDX_CH1_GAIN_LOW
        || a_idx == `CCR_IDX_CH0_GAIN_LOW)) |=>
        (hreadyout && hrdata[7:0] == 8'h00) or (!hreadyout ##1 (hrdata[7:0] == 8'h00));
  endproperty
  a_low_byte_zero: assert property (p_low_byte_zero) else $error("gain low byte nonzero");

  property p_offset_low_zero;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && (a_idx == `CCR_IDX_CH1_OFFSET_LOW
        || a_idx == `CCR_IDX_CH0_OFFSET_LOW)) |=>
        (hreadyout && hrdata[7:0] == 8'h00) or (!hreadyout ##1 (hrdata[7:0] == 8'h00));
  endproperty
  a_offset_low_zero: assert property (p_offset_low_zero) else $error("offset low byte nonzero");

  property p_cfg_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && (a_idx == `CCR_IDX_CH1_CONFIG)) |=>
        (hreadyout && hrdata[5:3] == 3'b000) or (!hreadyout ##1 (hrdata[5:3] == 3'b000));
  endproperty
  a_cfg_reserved_zero: assert property (p_cfg_reserved_zero) else $error("config reserved set");

  sequence s_cfg_write;
    wr_pend && (wr_idx == `CCR_IDX_CH1_CONFIG);
  endsequence
  property p_phase_follows;
    @(posedge hclk) disable iff (!hresetn)
      s_cfg_write |-> ##2 (ch1_phase_delay == $past(hwdata[15:6], 2));
  endproperty
  a_phase_follows: assert property (p_phase_follows) else $error("phase not applied");

  property p_mux_follows;
    @(posedge hclk) disable iff (!hresetn)
      s_cfg_write |-> ##2 (ch1_input_select == ccr_input_type'($past(hwdata[1:0], 2)));
  endproperty
  a_mux_follows: assert property (p_mux_follows) else $error("input select not applied");

  property p_bypass_gates;
    @(posedge hclk) disable iff (!hresetn)
      $past(ch1_dc_filter_bypass) |-> !ch1_dc_filter_active;
  endproperty
  a_bypass_gates: assert property (p_bypass_gates) else $error("filter active while bypassed");

  property p_dc_off_at_zero;
    @(posedge hclk) disable iff (!hresetn)
      ($past(global_dc_filter_coeff) == 4'h0) |-> (!ch1_dc_filter_active && ch1_dc_shift == 5'h00);
  endproperty
  a_dc_off_at_zero: assert property (p_dc_off_at_zero) else $error("filter on at zero");

  property p_gain_high_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH1_GAIN_HIGH) |-> ##2 (ch1_gain[23:8] == $past(hwdata[15:0], 2));
  endproperty
  a_gain_high_write: assert property (p_gain_high_write) else $error("gain high lost");

  property p_ch1_map;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH1_OFFSET_HIGH) |-> ##2 (ch1_offset[23:8] == $past(hwdata[15:0], 2));
  endproperty
  a_ch1_map: assert property (p_ch1_map) else $error("offset high lost");

  sequence s_read_meets_write;
    take && !hwrite && wr_pend;
  endsequence
  sequence s_one_wait_state;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait_state;
    @(posedge hclk) disable iff (!hresetn)
      s_read_meets_write |=> s_one_wait_state;
  endproperty
  a_read_wait_state: assert property (p_read_wait_state) else $error("no wait state on clash");

  property p_read_no_wait;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && !wr_pend) |=> hreadyout;
  endproperty
  a_read_no_wait: assert property (p_read_no_wait) else $error("needless wait state");

  property p_fresh_read;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH1_GAIN_HIGH && take && !hwrite
        && a_idx == `CCR_IDX_CH1_GAIN_HIGH && haddr[31:7] == 25'h0000000)
        |-> ##2 (hreadyout && hrdata[15:0] == $past(hwdata[15:0], 2));
  endproperty
  a_fresh_read: assert property (p_fresh_read) else $error("stale read after write");

  property p_shift_value;
    @(posedge hclk) disable iff (!hresetn)
      ($past(global_dc_filter_coeff) != 4'h0)
        |-> (ch1_dc_shift == 5'($past(global_dc_filter_coeff)) + 5'h01);
  endproperty
  a_shift_value: assert property (p_shift_value) else $error("coefficient shift wrong");

  property p_active_follows;
    @(posedge hclk) disable iff (!hresetn)
      (!$past(ch1_dc_filter_bypass) && ($past(global_dc_filter_coeff) != 4'h0))
        |-> ch1_dc_filter_active;
  endproperty
  a_active_follows: assert property (p_active_follows) else $error("filter not following");

  property p_offset_low_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH1_OFFSET_LOW) |-> ##2 (ch1_offset[7:0] == $past(hwdata[15:8], 2));
  endproperty
  a_offset_low_write: assert property (p_offset_low_write) else $error("offset low lost");

  property p_gain_low_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH0_GAIN_LOW) |-> ##2 (ch0_gain[7:0] == $past(hwdata[15:8], 2));
  endproperty
  a_gain_low_write: assert property (p_gain_low_write) else $error("gain low lost");

  property p_ch0_offset_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == `CCR_IDX_CH0_OFFSET_HIGH)
        |-> ##2 (ch0_offset[23:8] == $past(hwdata[15:0], 2));
  endproperty
  a_ch0_offset_write: assert property (p_ch0_offset_write) else $error("ch0 offset lost");
endmodule
`default_nettype wire

// ---- hw/ccr_cfg.svh ----
// Register offsets, field positions and reset values of the calibration bank
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_IDX_CH0_OFFSET_HIGH 5'h0a
`define CCR_IDX_CH0_OFFSET_LOW  5'h0b
`define CCR_IDX_CH0_GAIN_HIGH   5'h0c
`define CCR_IDX_CH0_GAIN_LOW    5'h0d
`define CCR_IDX_CH1_CONFIG      5'h0e
`define CCR_IDX_CH1_OFFSET_HIGH 5'h0f
`define CCR_IDX_CH1_OFFSET_LOW  5'h10
`define CCR_IDX_CH1_GAIN_HIGH   5'h11
`define CCR_IDX_CH1_GAIN_LOW    5'h12
`define CCR_IDX_GLOBAL_DC       5'h08
`define CCR_RST_OFFSET_HIGH     16'h0000
`define CCR_RST_GAIN_HIGH       16'h8000
`define CCR_RST_LOW_BYTE        8'h00
`define CCR_RST_CONFIG          16'h0000
`define CCR_RST_DC_COEFF        4'h0
`define CCR_RST_PHASE           10'h000
`define CCR_RST_BYPASS          1'b0
`define CCR_RST_MUX             2'b00
`define CCR_CFG_PHASE_MSB       15
`define CCR_CFG_PHASE_LSB       6
`define CCR_CFG_BYPASS_BIT      2
`define CCR_CFG_MUX_MSB         1
`define CCR_CFG_MUX_LSB         0
`endif

// ---- hw/ccr_pkg.sv ----
// Types of the calibration register bank
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_IN_PINS     = 2'b00,
    CCR_IN_SHORTED  = 2'b01,
    CCR_IN_TEST_POS = 2'b10,
    CCR_IN_TEST_NEG = 2'b11
  } ccr_input_type;
endpackage

// ---- verif/test_ccr_regs.sv ----
// Self-checking bench for the calibration register bank
`timescale 1ns/100ps
`default_nettype none
`include "ccr_cfg.svh"
module test_ccr_regs
  import ccr_pkg::*;
();
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic       [31:0] haddr;
  logic       [1:0]  htrans;
  logic              hwrite;
  logic       [2:0]  hsize;
  logic       [31:0] hwdata;
  logic       [31:0] hrdata;
  logic              hreadyout;
  logic              hresp;
  logic       [23:0] cal_out [4];
  logic signed [9:0] ch1_phase_delay;
  logic              ch1_dc_filter_active;
  ccr_input_type     ch1_input_select;
  logic       [4:0]  ch1_dc_shift;
  int                error_cnt;
  int                check_count;
  logic       [4:0]  idx_tab [10] = '{5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
                                     5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12};
  logic       [4:0]  hi_tab [4] = '{`CCR_IDX_CH0_OFFSET_HIGH, `CCR_IDX_CH0_GAIN_HIGH,
                                    `CCR_IDX_CH1_OFFSET_HIGH, `CCR_IDX_CH1_GAIN_HIGH};

  ccr_regs u_ccr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ch0_offset(cal_out[0]), .ch0_gain(cal_out[1]), .ch1_offset(cal_out[2]),
    .ch1_gain(cal_out[3]), .ch1_phase_delay(ch1_phase_delay),
    .ch1_dc_filter_active(ch1_dc_filter_active), .ch1_input_select(ch1_input_select),
    .ch1_dc_shift(ch1_dc_shift)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Wait for hready sampled high at a rising edge; the watchdog ends a hang
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge hclk);
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask

  function automatic logic [31:0] ba(input logic [4:0] idx);
    return {25'h0, idx, 2'b00};
  endfunction

  task automatic settle();
    @(posedge hclk);
    #1;
  endtask

  task automatic test_reset();
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      bus(ba(idx_tab[i]), 1'b0, 32'h0, d);
      chk(d, (i == 3 || i == 8) ? 32'h8000 : 32'h0, "reset word");
    end
    for (int i = 0; i < 4; i++) chk({8'h0, cal_out[i]}, i[0] ? 32'h800000 : 32'h0, "cal reset");
    chk({22'h0, ch1_phase_delay}, 32'h0, "phase reset");
    $display("test_reset done");
  endtask

  task automatic test_cal();
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      bus(ba(hi_tab[i]), 1'b1, {16'hffff, 16'hc350 + 16'(i)}, d);
      bus(ba(hi_tab[i] + 5'h1), 1'b1, {16'hffff, 8'h9a + 8'(i), 8'hff}, d);
    end
    for (int i = 0; i < 4; i++) begin
      bus(ba(hi_tab[i]), 1'b0, 32'h0, d);
      chk(d, {16'h0, 16'hc350 + 16'(i)}, "high word");
      bus(ba(hi_tab[i] + 5'h1), 1'b0, 32'h0, d);
      chk(d, {16'h0, 8'h9a + 8'(i), 8'h00}, "low word");
      chk({8'h0, cal_out[i]}, {8'h0, 16'hc350 + 16'(i), 8'h9a + 8'(i)}, "cal value");
    end
    $display("test_cal done");
  endtask

  task automatic test_config();
    logic [31:0] d;
    logic [9:0]  ph;
    for (int m = 0; m < 4; m++) begin
      ph = 10'h201 ^ 10'(m);
      bus(ba(`CCR_IDX_CH1_CONFIG), 1'b1, {16'h0, ph, 3'b111, m[0], m[1:0]}, d);
      bus(ba(`CCR_IDX_CH1_CONFIG), 1'b0, 32'h0, d);
      chk(d, {16'h0, ph, 3'b000, m[0], m[1:0]}, "config word");
      chk({22'h0, ch1_phase_delay}, {22'h0, ph}, "phase delay");
      chk({30'h0, ch1_input_select}, 32'(m), "input select");
    end
    $display("test_config done");
  endtask

  task automatic test_dc();
    logic [31:0] d;
    bus(ba(`CCR_IDX_CH1_CONFIG), 1'b1, 32'h0, d);
    for (int k = 0; k < 16; k++) begin
      bus(ba(`CCR_IDX_GLOBAL_DC), 1'b1, {28'h0, 4'(k)}, d);
      bus(ba(`CCR_IDX_GLOBAL_DC), 1'b0, 32'h0, d);
      chk(d, 32'(k), "dc setting");
      chk({27'h0, ch1_dc_shift}, (k == 0) ? 32'h0 : 32'(k + 1), "dc shift");
      chk({31'h0, ch1_dc_filter_active}, (k == 0) ? 32'h0 : 32'h1, "dc active");
    end
    bus(ba(`CCR_IDX_CH1_CONFIG), 1'b1, 32'h4, d);
    settle();
    chk({31'h0, ch1_dc_filter_active}, 32'h0, "bypass");
    $display("test_dc done");
  endtask

  task automatic test_unmapped();
    logic [31:0] d;
    bus(ba(5'h1f), 1'b1, 32'h1234, d);
    bus(ba(5'h1f), 1'b0, 32'h0, d);
    chk(d, 32'h0, "unmapped read");
    bus(32'h8000_0000 | ba(`CCR_IDX_CH0_GAIN_HIGH), 1'b1, 32'h1234, d);
    bus(ba(`CCR_IDX_CH0_GAIN_HIGH), 1'b0, 32'h0, d);
    chk(d, 32'h8000, "aliased write");
    $display("test_unmapped done");
  endtask

  // Read address phase overlapping the data phase of a write to the same word
  task automatic test_back_to_back();
    logic [31:0] d;
    @(posedge hclk);
    haddr  <= ba(`CCR_IDX_CH1_GAIN_HIGH);
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_ready();
    hwrite <= 1'b0;
    hwdata <= 32'h00001357;
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    d = hrdata;
    chk(d, 32'h00001357, "read after write");
    chk({31'h0, hresp}, 32'h0, "response");
    chk({8'h0, cal_out[3]}, 32'h00135700, "gain after pipelined write");
    $display("test_back_to_back done");
  endtask

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_cal();
    test_config();
    test_dc();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_unmapped();
    test_back_to_back();
    close_out();
  end
endmodule
`default_nettype wire
